// ==== rtl/fcc_defines.vh ====
`ifndef FCC_DEFINES_VH
`define FCC_DEFINES_VH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define FCC_CMD_PTR_A 8'h00
`define FCC_CMD_CB2 8'h8a
`define FCC_CMD_CONF 8'h10
`define FCC_CMD_CACHE 8'h15
`define FCC_CMD_PROG 8'h80
`define FCC_CMD_ERASE 8'h60
`define FCC_CMD_ERCONF 8'hd0
`define FCC_CMD_STATUS 8'h70
`define FCC_CMD_RESET 8'hff
// ----------------------------------------
// Operation codes on the user port
// ----------------------------------------
`define FCC_OP_COPY 3'h0
`define FCC_OP_CACHE 3'h1
`define FCC_OP_ERASE 3'h2
`define FCC_OP_RESET 3'h3
`define FCC_OP_STATUS 3'h4
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define FCC_SR_GEN_ERR 0
`define FCC_SR_PREV_ERR 1
`define FCC_SR_ENG_IDLE 5
`define FCC_SR_CACHE_RDY 6
// ----------------------------------------
// Counts
// ----------------------------------------
`define FCC_PAGE_BYTES 10'h210
`define FCC_MAX_CACHE_PAGES 6'h20
`define FCC_ADDR_CYCLES 3'h4
`define FCC_STROBE_CYCLES 4'h3
`endif

// ==== rtl/fcc_sync.v ====
`timescale 1ns/1ps
// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
module fcc_sync
(
  input wire core_clk, // Clock
  input wire rst, // Sync reset
  input wire ce, // Clock enable
  input wire din, // Raw pin
  output reg dout // Filtered level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Change counts once stages two and three agree
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      dout <= 1'b1;
    end
    else if (ce)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end
endmodule

// ==== rtl/fcc_ctrl.v ====
`timescale 1ns/1ps
`include "fcc_defines.vh"
// Operation
// - Wait ready high, then 8Ah, four target address cycles, confirm 10h.
// - Source and target pages keep the density-specific high address bits equal.
// - No partial program of copy back target before its block is erased.
// - Limit repeated copy back of same data, or strengthen error correction.
// - Cache program pages stay inside one erase block.
// - Only pointer 00h precedes a cache program sequence.
// - Cache step is setup, four address cycles, up to 528 data bytes.
// - Last cache page confirmed with 10h when only ready/busy is watched.
// - After 15h on last page, poll engine idle bit before other work.
// - At most 32 pages in one cache program operation.
// - Erase sends 60h, two or three row address cycles, then D0h.
// - Erase uses A14 upward; last address cycle drives data lines low.
module fcc_ctrl
#(
  parameter ROW_CYCLES = 3 // Erase row cycles: 3 for large, 2 small parts
)
(
  input wire core_clk, // Clock
  input wire rst, // Sync reset, high
  input wire ce, // Clock enable
  input wire req, // Start operation pulse
  input wire [2:0] op, // Operation code
  input wire [31:0] src_addr, // Source / page address, four bytes
  input wire [31:0] dst_addr, // Copy target address
  input wire last_page, // Cache: confirm with 10h
  input wire wr_valid, // Cache data byte valid
  input wire [7:0] wr_data, // Cache data byte
  input wire rb_pin, // Ready/busy from device
  input wire [7:0] io_in, // Data bus from device
  output reg wr_ready, // Cache data byte taken
  output reg busy, // Operation in progress
  output reg done, // Operation finished pulse
  output reg [7:0] status, // Last status read
  output reg limit_err, // Cache page refused: limit or block
  output reg cle, // Command latch enable
  output reg ale, // Address latch enable
  output reg we_n, // Write strobe, low
  output reg re_n, // Read strobe, low
  output reg ce_n, // Chip enable, low
  output reg [7:0] io_out, // Data bus to device
  output reg io_oe // Data bus drive enable
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam ST_IDLE = 4'h0;
  localparam ST_CMD = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_DATA = 4'h3;
  localparam ST_CONF = 4'h4;
  localparam ST_WAIT = 4'h5;
  localparam ST_STAT = 4'h6;
  localparam ST_RD = 4'h7;
  localparam ST_CB2 = 4'h8;
  localparam ST_PTR = 4'h9;
  // Erase row bytes kept; the last row cycle goes out as zero
  localparam [31:0] ER_KEEP = (32'h1 << (8 * (ROW_CYCLES - 1))) - 32'h1;

  wire rb;
  reg [3:0] st_r;
  reg [3:0] ret_r; // State after strobe
  reg [2:0] op_r;
  reg [7:0] byte_r; // Byte on the bus
  reg [3:0] tick_r; // Strobe phase counter
  reg [2:0] acnt_r; // Address cycles left
  reg [31:0] addr_r;
  reg [9:0] dcnt_r; // Data bytes sent
  reg [5:0] pages_r; // Cache pages this run
  reg stage_r; // Copy back second half
  reg [18:0] blk_r; // Block of the open cache run
  reg open_r; // A 15h page may still be programming
  // copy or erase turns into a status poll while a page may run
  wire hold_op = open_r && (op == `FCC_OP_COPY || op == `FCC_OP_ERASE);
  wire [2:0] op_eff = hold_op ? `FCC_OP_STATUS : op;

  fcc_sync u_rb
  (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .din(rb_pin),
    .dout(rb)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      ret_r <= ST_IDLE;
      op_r <= 3'h0;
      byte_r <= 8'h00;
      tick_r <= 4'h0;
      acnt_r <= 3'h0;
      addr_r <= 32'h00000000;
      dcnt_r <= 10'h000;
      pages_r <= 6'h00;
      stage_r <= 1'b0;
      blk_r <= 19'h00000;
      open_r <= 1'b0;
      wr_ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      status <= 8'h00;
      limit_err <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      ce_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      wr_ready <= 1'b0;
      limit_err <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (req)
          begin
            op_r <= op_eff;
            stage_r <= 1'b0;
            busy <= 1'b1;
            ce_n <= 1'b0;
            tick_r <= 4'h0;
            case (op_eff)
              `FCC_OP_COPY:
              begin
                byte_r <= `FCC_CMD_PTR_A;
                addr_r <= src_addr;
                acnt_r <= `FCC_ADDR_CYCLES;
                ret_r <= ST_ADDR;
                st_r <= ST_CMD;
              end
              `FCC_OP_CACHE:
              begin
                // refuse a page outside the run's block
                if (pages_r == `FCC_MAX_CACHE_PAGES ||
                    (pages_r != 6'h00 && src_addr[31:13] != blk_r))
                begin
                  limit_err <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  ce_n <= 1'b1;
                  pages_r <= 6'h00;
                end
                else
                begin
                  byte_r <= `FCC_CMD_PTR_A;
                  blk_r <= src_addr[31:13];
                  addr_r <= src_addr;
                  ret_r <= ST_PTR;
                  st_r <= ST_CMD;
                end
              end
              `FCC_OP_ERASE:
              begin
                byte_r <= `FCC_CMD_ERASE;
                // last row cycle sent as zero
                addr_r <= {8'h00, src_addr[31:8]} & ER_KEEP;
                acnt_r <= ROW_CYCLES[2:0];
                ret_r <= ST_ADDR;
                st_r <= ST_CMD;
              end
              `FCC_OP_RESET:
              begin
                byte_r <= `FCC_CMD_RESET;
                pages_r <= 6'h00;
                open_r <= 1'b0;
                ret_r <= ST_WAIT;
                st_r <= ST_CMD;
              end
              default:
              begin
                byte_r <= `FCC_CMD_STATUS;
                ret_r <= ST_RD;
                st_r <= ST_CMD;
              end
            endcase
          end
        end
        ST_PTR:
        begin
          byte_r <= `FCC_CMD_PROG;
          acnt_r <= `FCC_ADDR_CYCLES;
          ret_r <= ST_ADDR;
          st_r <= ST_CMD;
        end
        ST_CMD, ST_CONF:
        begin
          // Command cycle: setup, strobe low, release
          tick_r <= tick_r + 4'h1;
          cle <= (st_r == ST_CMD) || (st_r == ST_CONF);
          ale <= 1'b0;
          io_out <= byte_r;
          io_oe <= 1'b1;
          if (tick_r == 4'h1)
            we_n <= 1'b0;
          if (tick_r == `FCC_STROBE_CYCLES)
          begin
            we_n <= 1'b1;
            tick_r <= 4'h0;
            st_r <= ret_r;
            if (ret_r == ST_ADDR && acnt_r != 3'h0)
            begin
              byte_r <= addr_r[7:0];
              addr_r <= {8'h00, addr_r[31:8]};
            end
          end
        end
        ST_ADDR:
        begin
          if (acnt_r == 3'h0)
          begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            if (op_r == `FCC_OP_ERASE)
            begin
              byte_r <= `FCC_CMD_ERCONF;
              ret_r <= ST_WAIT;
              st_r <= ST_CONF;
            end
            else if (op_r == `FCC_OP_CACHE)
            begin
              dcnt_r <= 10'h000;
              st_r <= ST_DATA;
            end
            else if (!stage_r)
            begin
              st_r <= ST_WAIT;
            end
            else
            begin
              byte_r <= `FCC_CMD_CONF;
              ret_r <= ST_WAIT;
              st_r <= ST_CONF;
            end
          end
          else
          begin
            // Address cycle: ale with the next byte
            tick_r <= tick_r + 4'h1;
            cle <= 1'b0;
            ale <= 1'b1;
            io_out <= byte_r;
            io_oe <= 1'b1;
            if (tick_r == 4'h1)
              we_n <= 1'b0;
            if (tick_r == `FCC_STROBE_CYCLES)
            begin
              we_n <= 1'b1;
              tick_r <= 4'h0;
              acnt_r <= acnt_r - 3'h1;
              byte_r <= addr_r[7:0];
              addr_r <= {8'h00, addr_r[31:8]};
            end
          end
        end
        ST_DATA:
        begin
          tick_r <= tick_r + 4'h1;
          io_oe <= 1'b1;
          if (tick_r == 4'h0)
          begin
            if (dcnt_r == `FCC_PAGE_BYTES || !wr_valid)
            begin
              tick_r <= 4'h0;
              if (dcnt_r == `FCC_PAGE_BYTES || dcnt_r != 10'h000)
              begin
                byte_r <= last_page ? `FCC_CMD_CONF : `FCC_CMD_CACHE;
                ret_r <= ST_WAIT;
                st_r <= ST_CONF;
                pages_r <= last_page ? 6'h00 : pages_r + 6'h01;
                open_r <= !last_page;
              end
            end
            else
            begin
              io_out <= wr_data;
              wr_ready <= 1'b1;
            end
          end
          if (tick_r == 4'h1)
            we_n <= 1'b0;
          if (tick_r == `FCC_STROBE_CYCLES)
          begin
            we_n <= 1'b1;
            tick_r <= 4'h0;
            dcnt_r <= dcnt_r + 10'h001;
          end
        end
        ST_WAIT:
        begin
          // wait for ready after confirm, reset or copy source address
          cle <= 1'b0;
          io_oe <= 1'b0;
          tick_r <= tick_r + 4'h1;
          if (tick_r == 4'hf && rb)
          begin
            tick_r <= 4'h0;
            if (op_r == `FCC_OP_COPY && !stage_r)
            begin
              stage_r <= 1'b1;
              st_r <= ST_CB2;
            end
            else if (op_r == `FCC_OP_RESET)
            begin
              busy <= 1'b0;
              done <= 1'b1;
              ce_n <= 1'b1;
              st_r <= ST_IDLE;
            end
            else
            begin
              byte_r <= `FCC_CMD_STATUS;
              ret_r <= ST_RD;
              st_r <= ST_CMD;
            end
          end
          else if (tick_r == 4'hf)
            tick_r <= 4'hf;
        end
        ST_CB2:
        begin
          // caller keeps plane bits equal in dst_addr
          // no partial program issued; caller limits repeats
          byte_r <= `FCC_CMD_CB2;
          addr_r <= dst_addr;
          acnt_r <= `FCC_ADDR_CYCLES;
          ret_r <= ST_ADDR;
          st_r <= ST_CMD;
        end
        ST_RD:
        begin
          // capture idle, cache ready and error bits
          cle <= 1'b0;
          io_oe <= 1'b0;
          tick_r <= tick_r + 4'h1;
          if (tick_r == 4'h0)
            re_n <= 1'b0;
          if (tick_r == `FCC_STROBE_CYCLES)
          begin
            // page N-1 and page N errors
            status <= io_in;
            if (io_in[`FCC_SR_ENG_IDLE])
              open_r <= 1'b0;
            re_n <= 1'b1;
            tick_r <= 4'h0;
            busy <= 1'b0;
            done <= 1'b1;
            ce_n <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/fcc_ctrl_assertions.sv ====
`timescale 1ns/1ps
`include "fcc_defines.vh"
// ----------------------------------------
// Pin protocol checker
// ----------------------------------------
module fcc_ctrl_assertions
(
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire req, // Start
  input wire [2:0] op, // Op code
  input wire done, // Finish
  input wire limit_err, // Refused
  input wire rb_pin, // Ready
  input wire cle, // Cmd latch
  input wire ale, // Addr latch
  input wire we_n, // Write
  input wire re_n, // Read
  input wire ce_n, // Select
  input wire [7:0] io_out, // Bus
  input wire io_oe // Drive
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Bus cycle shape: two low clocks, bus held meanwhile
  property p_sel; !we_n |-> !ce_n; endproperty
  a_sel: assert property (p_sel)
    else $error("strobe unselected");
  property p_pulse; $fell(we_n) |=> !we_n ##1 we_n; endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe width");
  property p_hold; $fell(we_n) |=> $stable({io_out, cle, ale}); endproperty
  a_hold: assert property (p_hold)
    else $error("bus moved in strobe");
  property p_drv; !we_n |-> io_oe; endproperty
  a_drv: assert property (p_drv)
    else $error("bus undriven");
  property p_one; cle |-> !ale; endproperty
  a_one: assert property (p_one)
    else $error("cle with ale");
  property p_rd; !re_n |-> we_n && !io_oe; endproperty
  a_rd: assert property (p_rd)
    else $error("read clash");
  // Raw pin busy of four clocks must hold writes off
  property p_rb; !rb_pin [*4] |-> we_n; endproperty
  a_rb: assert property (p_rb)
    else $error("write while busy");
  property p_lim; limit_err |-> done && we_n; endproperty
  a_lim: assert property (p_lim)
    else $error("limit without done");
  c_cp: cover property (req && op == `FCC_OP_COPY);
  c_er: cover property (req && op == `FCC_OP_ERASE);
  c_lim: cover property (limit_err);
endmodule

// ==== tb/fcc_flash_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural flash device
// ----------------------------------------
module fcc_flash_model
(
  input wire cle, // Cmd latch
  input wire ale, // Addr latch
  input wire we_n, // Write
  input wire re_n, // Read
  input wire ce_n, // Select
  input wire [7:0] io_out, // Bus in
  input wire fail, // Next program or erase fails
  output reg rb_pin, // Ready/busy
  output wire [7:0] io_in // Bus out
);
  reg [9:0] log_q[$];
  reg [7:0] cmd_r = 8'h70;
  reg idle_r = 1'b1, gerr_r = 1'b0, perr_r = 1'b0;
  reg chain_r = 1'b0, rst_r = 1'b0;
  integer ac = 0, gen = 0;
  time pend = 0, rem;
  wire [7:0] stv = {1'b1, rb_pin, rb_pin & idle_r, 3'h0, perr_r, gerr_r};
  initial rb_pin = 1'b1;
  // Released bus shows the inverse so stale data never matches
  // status stays readable
  assign io_in = (!re_n && !ce_n) ? stv : ~stv;
  // Busy windows; a newer one cancels older ones
  task automatic go_busy(input time rb_ns, input time eng_ns);
    integer g;
    begin
      gen = gen + 1;
      g = gen;
      idle_r = 1'b0;
      pend = $time + 50 + eng_ns;
      fork
        begin
          #50 if (g == gen) rb_pin = 1'b0;
          #(rb_ns) if (g == gen) rb_pin = 1'b1;
        end
        #(50 + eng_ns) if (g == gen) idle_r = 1'b1;
      join_none
    end
  endtask
  // decode, busy takes status or reset
  task take_cmd(input [7:0] c);
    begin
      if (c == 8'hff && !rst_r)
      begin
        go_busy((rem > 0) ? 1000 : 200, 200);
        {gerr_r, perr_r, chain_r, rst_r} = 4'h1;
        cmd_r = 8'h70;
      end
      else if (rb_pin && c != 8'hff && c != 8'h70)
      begin
        rst_r = 1'b0;
        if (c == 8'h00 || c == 8'h80 || c == 8'h8a || c == 8'h60)
          cmd_r = c;
        else if (c == 8'hd0 && cmd_r == 8'h60)
        begin
          {gerr_r, perr_r} = {fail, 1'b0};
          go_busy(2000, 2000);
        end
        else if ((c == 8'h10 || c == 8'h15) &&
                 (cmd_r == 8'h80 || cmd_r == 8'h8a))
        begin
          {perr_r, gerr_r} = {chain_r & gerr_r, fail};
          chain_r = (c == 8'h15);
          go_busy(rem + (chain_r ? 300 : 1300), rem + 1300);
          cmd_r = 8'h70;
        end
      end
    end
  endtask
  // latch write cycles; page read after four addresses
  always @(posedge we_n)
  begin
    if (ce_n === 1'b0)
    begin
      log_q.push_back({cle, ale, io_out});
      rem = (pend > $time) ? pend - $time : 0;
      ac = ale ? ac + 1 : 0;
      if (ale && cmd_r == 8'h00 && ac == 4)
        go_busy(1000, 1000);
      if (cle)
        take_cmd(io_out);
    end
  end
endmodule

// ==== tb/flash_copyback_cache_erase_tb.sv ====
`timescale 1ns/1ps
`include "fcc_defines.vh"
// ----------------------------------------
// Scenario bench
// ----------------------------------------
module flash_copyback_cache_erase_tb;
  reg core_clk = 1'b0, rst = 1'b1, ce = 1'b1, req = 1'b0;
  reg [2:0] op = 3'h0;
  reg [31:0] src_addr = 32'h0, dst_addr = 32'h0;
  reg last_page = 1'b0, wr_valid = 1'b0, fail = 1'b0, seen_lim = 1'b0;
  reg [7:0] wr_data = 8'h00;
  wire rb_pin, wr_ready, busy, done, limit_err, cle, ale;
  wire we_n, re_n, ce_n, io_oe;
  wire [7:0] io_in, status, io_out;
  reg [9:0] exp_q[$];
  integer fail_count = 0, comparisons = 0, cyc = 0, n;
  fcc_ctrl dut
  (
    .core_clk(core_clk), .rst(rst), .ce(ce), .req(req), .op(op),
    .src_addr(src_addr), .dst_addr(dst_addr), .last_page(last_page),
    .wr_valid(wr_valid), .wr_data(wr_data), .rb_pin(rb_pin),
    .io_in(io_in), .wr_ready(wr_ready), .busy(busy), .done(done),
    .status(status), .limit_err(limit_err), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .ce_n(ce_n), .io_out(io_out), .io_oe(io_oe)
  );
  fcc_flash_model dev
  (
    .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .ce_n(ce_n),
    .io_out(io_out), .fail(fail), .rb_pin(rb_pin), .io_in(io_in)
  );
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  // Hang guard, far above the longest run
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  task close_out;
    begin
      $display("Counts: %0d bad of %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Wire log against expectation, then both are emptied
  task chk_log;
    integer i;
    begin
      chk(16'(dev.log_q.size()), 16'(exp_q.size()));
      for (i = 0; i < exp_q.size() && i < dev.log_q.size(); i = i + 1)
        chk({6'h0, dev.log_q[i]}, {6'h0, exp_q[i]});
      dev.log_q.delete();
      exp_q.delete();
    end
  endtask
  task ex(input [1:0] k, input [7:0] b);
    exp_q.push_back({k, b});
  endtask
  task ex_addr(input [31:0] a, input integer lo, input integer cnt);
    integer i;
    for (i = lo; i < lo + cnt; i = i + 1)
      ex(2'h1, a[8 * i +: 8]);
  endtask
  task ex_page(input [31:0] a, input integer nb, input [7:0] conf);
    integer i;
    begin
      ex(2'h2, 8'h00);
      ex(2'h2, 8'h80);
      ex_addr(a, 0, 4);
      for (i = 0; i < nb; i = i + 1)
        ex(2'h0, 8'h5a ^ i[7:0]);
      ex(2'h2, conf);
      ex(2'h2, 8'h70);
    end
  endtask
  // One request, data fed on each taken byte, bounded wait for done
  task run_op(input [2:0] o, input [31:0] s, input [31:0] d,
    input l, input integer nb, input f);
    integer i, k;
    begin
      @(posedge core_clk);
      {op, src_addr, dst_addr, last_page, fail} <= {o, s, d, l, f};
      req <= 1'b1;
      wr_valid <= (nb > 0);
      wr_data <= 8'h5a;
      @(posedge core_clk);
      req <= 1'b0;
      i = 0;
      k = 0;
      while (i < 4000 && done !== 1'b1)
      begin
        @(negedge core_clk);
        i = i + 1;
        if (i == 1)
          chk({15'h0, busy | limit_err}, 16'h1);
        if (wr_ready === 1'b1)
          k = k + 1;
        if (limit_err === 1'b1)
          seen_lim = 1'b1;
        if (done !== 1'b1)
        begin
          @(posedge core_clk);
          wr_valid <= (k < nb);
          wr_data <= 8'h5a ^ k[7:0];
        end
      end
      chk({15'h0, done}, 16'h1);
      chk({15'h0, busy}, 16'h0);
      @(posedge core_clk);
      wr_valid <= 1'b0;
    end
  endtask
  task op0(input [2:0] o);
    run_op(o, 32'h0, 32'h0, 1'b0, 0, 1'b0);
  endtask
  task t_rst;
    begin
      op0(`FCC_OP_RESET);
      op0(`FCC_OP_STATUS);
      ex(2'h2, 8'hff);
      ex(2'h2, 8'h70);
      chk({8'h0, status}, 16'he0);
      chk_log;
      $display("reset test end");
    end
  endtask
  // Failing copy; top address byte shared by both pages
  task t_copy;
    begin
      run_op(`FCC_OP_COPY, 32'h020a1100, 32'h020b2200, 1'b0, 0, 1'b1);
      ex(2'h2, 8'h00);
      ex_addr(32'h020a1100, 0, 4);
      ex(2'h2, 8'h8a);
      ex_addr(32'h020b2200, 0, 4);
      ex(2'h2, 8'h10);
      ex(2'h2, 8'h70);
      chk({8'h0, status}, 16'he1);
      chk_log;
      $display("copy test end");
    end
  endtask
  // Failing page then last page confirmed with 10h
  task t_cache;
    begin
      run_op(`FCC_OP_CACHE, 32'h00054000, 32'h0, 1'b0, 3, 1'b1);
      ex_page(32'h00054000, 3, 8'h15);
      chk({8'h0, status}, 16'hc1);
      chk_log;
      seen_lim = 1'b0;
      run_op(`FCC_OP_CACHE, 32'h00074000, 32'h0, 1'b0, 1, 1'b0);
      chk({15'h0, seen_lim}, 16'h1);
      run_op(`FCC_OP_CACHE, 32'h00054100, 32'h0, 1'b1, 2, 1'b0);
      ex_page(32'h00054100, 2, 8'h10);
      chk({8'h0, status}, 16'he2);
      chk_log;
      $display("cache test end");
    end
  endtask
  task t_erase;
    begin
      run_op(`FCC_OP_ERASE, 32'h7f123456, 32'h0, 1'b0, 0, 1'b0);
      ex(2'h2, 8'h60);
      ex_addr(32'h7f123456, 1, 2);
      ex(2'h1, 8'h00);
      ex(2'h2, 8'hd0);
      ex(2'h2, 8'h70);
      chk({8'h0, status}, 16'he0);
      chk_log;
      $display("erase test end");
    end
  endtask
  // 32 pages pass, the 33rd is refused without bus traffic
  task t_limit;
    begin
      for (n = 0; n < 32; n = n + 1)
        run_op(`FCC_OP_CACHE, {16'h0006, n[7:0], 8'h00}, 32'h0, 1'b0, 1, 1'b0);
      dev.log_q.delete();
      seen_lim = 1'b0;
      run_op(`FCC_OP_CACHE, 32'h00062000, 32'h0, 1'b0, 1, 1'b0);
      chk({15'h0, seen_lim}, 16'h1);
      chk_log;
      // Erase is held back as a status poll
      run_op(`FCC_OP_ERASE, 32'h00123456, 32'h0, 1'b0, 0, 1'b0);
      ex(2'h2, 8'h70);
      chk_log;
      n = 0;
      while (n < 20 && status[5] !== 1'b1)
      begin
        op0(`FCC_OP_STATUS);
        n = n + 1;
      end
      chk({15'h0, status[5]}, 16'h1);
      dev.log_q.delete();
      $display("limit test end");
    end
  endtask
  // Second reset lands on a device already reset
  task t_rst2;
    begin
      op0(`FCC_OP_RESET);
      op0(`FCC_OP_RESET);
      op0(`FCC_OP_STATUS);
      ex(2'h2, 8'hff);
      ex(2'h2, 8'hff);
      ex(2'h2, 8'h70);
      chk({8'h0, status}, 16'he0);
      chk_log;
      $display("double reset test end");
    end
  endtask
  // Clock enable low freezes a status read part way
  task t_hold;
    begin
      @(posedge core_clk);
      op <= `FCC_OP_STATUS;
      req <= 1'b1;
      @(posedge core_clk);
      req <= 1'b0;
      ce <= 1'b0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      chk({14'h0, busy, done}, 16'h2);
      @(posedge core_clk);
      ce <= 1'b1;
      n = 0;
      while (n < 40 && done !== 1'b1)
      begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk({15'h0, done}, 16'h1);
      ex(2'h2, 8'h70);
      chk_log;
      $display("hold test end");
    end
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_rst;
    t_copy;
    t_cache;
    t_erase;
    t_limit;
    t_rst2;
    t_hold;
    close_out;
  end
endmodule
bind fcc_ctrl fcc_ctrl_assertions u_chk
(
  .core_clk(core_clk), .rst(rst), .req(req), .op(op), .done(done),
  .limit_err(limit_err), .rb_pin(rb_pin), .cle(cle), .ale(ale),
  .we_n(we_n), .re_n(re_n), .ce_n(ce_n), .io_out(io_out), .io_oe(io_oe)
);
